/* src/thermal_trip_monitor.sv */
`timescale 1ns/1ns
module thermal_trip_monitor
  import ttm_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Monitor side
  input  wire ttm_temps_s  zone_temps,
  input  wire logic        monitor_cycle_done,
  input  wire logic        main_power_good,
  input  wire logic        lock_bit,
  // Outputs
  output logic             overtemp_trip_out_n,
  output logic             trip_irq
);

  logic [7:0]       pin_ctl_r;
  logic [7:0]       lim_r1_r;
  logic [7:0]       lim_r2_r;
  logic [7:0]       lim_amb_r;
  logic [7:0]       rsv_b_r;
  logic [7:0]       rsv_c_r;
  logic [2:0]       status_r;
  logic [2:0]       out_en_r;
  logic [2:0]       irq_en_r;
  logic [2:0]       irq_sts_r;
  logic             pgood_d_r;
  logic [2:0]       exceed;
  logic [2:0]       tripped;
  logic [2:0]       trip_active;
  logic [7:0]       zone_temp [NZONE];
  logic [7:0]       zone_lim  [NZONE];
  ttm_zone_e        zone_st_r [NZONE];
  logic             acc;
  logic             wr;
  logic             rd;
  logic [7:0]       idx;
  logic             idx_ok;
  logic             aligned;
  logic [7:0]       wbyte;
  logic [7:0]       rbyte;

  // Access decode; one wait-free access phase
  assign acc     = psel & penable & clk_en;
  assign idx     = paddr[9:2];
  assign aligned = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
  assign wbyte   = pwdata[7:0];
  assign idx_ok  = aligned && (idx == IDX_RSV_A || idx == IDX_RSV_B || idx == IDX_RSV_C
                   || idx == IDX_PIN_CTL || idx == IDX_LIM_R1 || idx == IDX_LIM_R2
                   || idx == IDX_LIM_AMB || idx == IDX_STATUS || idx == IDX_OUT_EN
                   || idx == IDX_IRQ_EN || idx == IDX_IRQ_STS);
  // Byte lane 0 must be strobed for a write to land
  assign wr      = acc & pwrite & idx_ok & pstrb[0];
  assign rd      = acc & ~pwrite & idx_ok;

  // Zone mapping of readings and limits
  assign zone_temp[ZB_AMB] = zone_temps.ambient_zone;
  assign zone_temp[ZB_R1]  = zone_temps.rem_one;
  assign zone_temp[ZB_R2]  = zone_temps.rem_two;
  assign zone_lim[ZB_AMB]  = lim_amb_r;
  assign zone_lim[ZB_R1]   = lim_r1_r;
  assign zone_lim[ZB_R2]   = lim_r2_r;

  // Per-zone comparison and qualification
  for (genvar z = 0; z < NZONE; z++)
  begin : g_zone
    // R13 signed strict compare
    // R4 own trip limit only
    assign exceed[z]  = $signed(zone_temp[z]) > $signed(zone_lim[z]);
    assign tripped[z] = (zone_st_r[z] == ST_TRIP);
    // R5 enable gates zone
    assign trip_active[z] = tripped[z] & out_en_r[z];

    // R2 two consecutive cycles
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        zone_st_r[z] <= ST_BELOW;
      else if (clk_en && monitor_cycle_done)
      begin
        case (zone_st_r[z])
          ST_BELOW: zone_st_r[z] <= exceed[z] ? ST_ONCE : ST_BELOW;
          ST_ONCE:  zone_st_r[z] <= exceed[z] ? ST_TRIP : ST_BELOW;
          ST_TRIP:  zone_st_r[z] <= exceed[z] ? ST_TRIP : ST_BELOW;
          default:  zone_st_r[z] <= ST_BELOW;
        endcase
      end
    end
  end

  // Power-good edge tracker
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pgood_d_r <= 1'b0;
    else if (clk_en)
      pgood_d_r <= main_power_good;
  end

  // Trip status; set beats clear, power-good rise resets
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      status_r <= ZONE_RST;
    else if (clk_en)
    begin
      // R9 power-good rise clears
      if (main_power_good && !pgood_d_r)
        status_r <= ZONE_RST;
      // R1 R7 R8 sticky, W1C when inactive
      else if (wr && idx == IDX_STATUS)
        status_r <= (status_r & ~(wbyte[2:0] & ~tripped)) | tripped;
      else
        status_r <= status_r | tripped;
    end
  end

  // Control registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_ctl_r <= PIN_CTL_RST;
      rsv_b_r   <= RSV_RST;
      rsv_c_r   <= RSV_RST;
      irq_en_r  <= ZONE_RST;
    end
    else if (wr)
    begin
      // R12 reserved B and C stored as written
      if (idx == IDX_PIN_CTL)
        pin_ctl_r <= wbyte;
      if (idx == IDX_RSV_B)
        rsv_b_r <= wbyte;
      if (idx == IDX_RSV_C)
        rsv_c_r <= wbyte;
      if (idx == IDX_IRQ_EN)
        irq_en_r <= wbyte[2:0];
    end
  end

  // Lockable limits and enables
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lim_r1_r  <= LIMIT_RST;
      lim_r2_r  <= LIMIT_RST;
      lim_amb_r <= LIMIT_RST;
      out_en_r  <= ZONE_RST;
    end
    // R10 lock blocks writes
    else if (wr && !lock_bit)
    begin
      // R3 limit registers
      if (idx == IDX_LIM_R1)
        lim_r1_r <= wbyte;
      if (idx == IDX_LIM_R2)
        lim_r2_r <= wbyte;
      if (idx == IDX_LIM_AMB)
        lim_amb_r <= wbyte;
      // R11 zone bit order
      if (idx == IDX_OUT_EN)
        out_en_r <= wbyte[2:0];
    end
  end

  // Interrupt status, read-to-clear; new event wins over the clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_sts_r <= ZONE_RST;
    else if (clk_en)
    begin
      if (rd && idx == IDX_IRQ_STS)
        irq_sts_r <= tripped & ~status_r;
      else
        irq_sts_r <= irq_sts_r | (tripped & ~status_r);
    end
  end

  // Registered outputs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      overtemp_trip_out_n <= 1'b1;
      trip_irq            <= 1'b0;
    end
    else if (clk_en)
    begin
      // R6 global pin control
      overtemp_trip_out_n <= ~(pin_ctl_r[PIN_CTL_BIT] & (|trip_active));
      trip_irq            <= |(irq_sts_r & irq_en_r);
    end
  end

  // Read mux
  always_comb
  begin
    rbyte = 8'h00;
    case (idx)
      IDX_RSV_B:   rbyte = rsv_b_r;
      IDX_RSV_C:   rbyte = rsv_c_r;
      IDX_PIN_CTL: rbyte = pin_ctl_r;
      IDX_LIM_R1:  rbyte = lim_r1_r;
      IDX_LIM_R2:  rbyte = lim_r2_r;
      IDX_LIM_AMB: rbyte = lim_amb_r;
      IDX_STATUS:  rbyte = {5'h00, status_r};
      IDX_OUT_EN:  rbyte = {5'h00, out_en_r};
      IDX_IRQ_EN:  rbyte = {5'h00, irq_en_r};
      IDX_IRQ_STS: rbyte = {5'h00, irq_sts_r};
      default:     rbyte = 8'h00;
    endcase
  end

  // APB answer: ready and data registered in the setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end
    else if (clk_en)
    begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~idx_ok;
      prdata  <= (psel && !penable && !pwrite && idx_ok) ? {24'h0, rbyte} : 32'h0;
    end
  end

endmodule

/* src/ttm_pkg.sv */
// Behaviour
// R1 - One sticky trip status bit per zone
// R2 - Two consecutive over-limit cycles before trip
// R3 - Three 8-bit trip limits, reset 7Fh
// R4 - Trip limits independent of high limits
// R5 - Trip output needs zone enable and exceed
// R6 - Global trip-pin control bit 1 gates output
// R7 - Status holds until software writes one
// R8 - Write-one clears only when trip inactive
// R9 - Status cleared on power-good rising edge
// R10 - Lock makes limits and enables read-only
// R11 - Ambient bit0, remote one bit1, remote two bit2
// R12 - Software keeps reserved registers at defaults
// R13 - Signed strictly-greater comparison of temperatures
package ttm_pkg;

  localparam int NZONE = 3;

  // Printed offsets are register indices; byte address is four times
  localparam logic [7:0] IDX_RSV_A    = 8'hbd;
  localparam logic [7:0] IDX_RSV_B    = 8'hbf;
  localparam logic [7:0] IDX_RSV_C    = 8'hc0;
  localparam logic [7:0] IDX_PIN_CTL  = 8'hc1;
  localparam logic [7:0] IDX_LIM_R1   = 8'hc4;
  localparam logic [7:0] IDX_LIM_R2   = 8'hc5;
  localparam logic [7:0] IDX_LIM_AMB  = 8'hc9;
  localparam logic [7:0] IDX_STATUS   = 8'hca;
  localparam logic [7:0] IDX_OUT_EN   = 8'hcb;
  localparam logic [7:0] IDX_IRQ_EN   = 8'hce;
  localparam logic [7:0] IDX_IRQ_STS  = 8'hcf;

  // Zone bit positions
  localparam int ZB_AMB = 0;
  localparam int ZB_R1  = 1;
  localparam int ZB_R2  = 2;

  // Field positions and resets
  localparam int         PIN_CTL_BIT  = 1;
  localparam logic [7:0] PIN_CTL_RST  = 8'h01;
  localparam logic [7:0] LIMIT_RST    = 8'h7f;
  localparam logic [7:0] RSV_RST      = 8'h00;
  localparam logic [2:0] ZONE_RST     = 3'h0;

  // Zone readings grouped together
  typedef struct packed {
    logic [7:0] rem_two;
    logic [7:0] rem_one;
    logic [7:0] ambient_zone;
  } ttm_temps_s;

  // Sampling state per zone
  typedef enum logic [2:0] {
    ST_BELOW = 3'b001,
    ST_ONCE  = 3'b010,
    ST_TRIP  = 3'b100
  } ttm_zone_e;

endpackage

/* dv/ttm_chk.sv */
`timescale 1ns/1ns
module ttm_chk
(
  // Clock, reset, run enable
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        clk_en,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Trip side
  input wire logic        monitor_cycle_done,
  input wire logic        overtemp_trip_out_n
);
  logic [1:0] np_r, nw_r;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Saturating counts: lower bounds on what a trip needs first
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      np_r <= 2'h0;
      nw_r <= 2'h0;
    end
    else
    begin
      if (clk_en && monitor_cycle_done && np_r != 2'h2)
        np_r <= np_r + 2'h1;
      if (psel && penable && pready && pwrite && nw_r != 2'h2)
        nw_r <= nw_r + 2'h1;
    end

  a_ready_setup: assert property (psel && !penable && clk_en |=> pready)
    else $error("no ready");
  a_ready_once: assert property (pready |=> !pready)
    else $error("ready held");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_err_align: assert property (psel && !penable && clk_en && paddr[1:0] != 2'h0 |=> pslverr)
    else $error("misaligned accepted");
  a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper bits set");
  a_freeze_pin: assert property (!clk_en |=> $stable(overtemp_trip_out_n))
    else $error("pin moved while frozen");
  a_trip_pulses: assert property (!overtemp_trip_out_n |-> np_r == 2'h2)
    else $error("early trip");
  a_trip_enabled: assert property (!overtemp_trip_out_n |-> nw_r == 2'h2)
    else $error("trip not enabled");
endmodule

bind thermal_trip_monitor ttm_chk u_chk (.*);

/* dv/ttm_pwr_sys.sv */
`timescale 1ns/1ns
module ttm_pwr_sys
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Trip in, restart in, power good out
  input wire logic overtemp_trip_out_n,
  input wire logic restart,
  output logic     main_power_good
);
  // A trip cuts power; only a restart or a reset brings it back
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      main_power_good <= 1'b1;
    else if (!overtemp_trip_out_n)
      main_power_good <= 1'b0;
    else if (restart)
      main_power_good <= 1'b1;
endmodule

/* dv/thermal_trip_monitor_tb.sv */
`timescale 1ns/1ns
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin err_total++; \
  $display("[ERR] %s exp %0h got %0h", n, e, a); end end
module thermal_trip_monitor_tb
  import ttm_pkg::*;
;
  logic        pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0;
  logic        mcd = 0, lock = 0, restart = 0, pready, pslverr, er, trip_n, irq, pg;
  logic [11:0] paddr = 0;
  logic [3:0]  strb = 4'hf;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [7:0]  lim [3] = '{IDX_LIM_AMB, IDX_LIM_R1, IDX_LIM_R2};
  ttm_temps_s  temps = '0;
  int          err_total = 0, compares = 0;

  // Clock
  always #4 pclk = ~pclk;

  thermal_trip_monitor u_dut (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb(strb), .prdata, .pready, .pslverr, .zone_temps(temps),
    .monitor_cycle_done(mcd), .main_power_good(pg), .lock_bit(lock),
    .overtemp_trip_out_n(trip_n), .trip_irq(irq));
  ttm_pwr_sys u_pwr (.pclk, .presetn, .overtemp_trip_out_n(trip_n), .restart,
    .main_power_good(pg));

  // Verdict
  task automatic results;
    $display("compares %0d errors %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // One APB transfer, bounded wait on pready
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d,
                     input logic [1:0] lo = 2'h0);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {2'h0, idx, lo};
    pwdata  <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (!pready && n < 20)
    begin
      @(posedge pclk);
      n++;
    end
    if (!pready)
    begin
      err_total++;
      results();
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Read a word and compare
  task automatic rdc(input logic [7:0] idx, input logic [7:0] e, input string s);
    apb(1'b0, idx, 8'h0);
    `CHK(s, {24'h0, e}, rd)
  endtask

  // One monitoring cycle with one zone reading
  task automatic pulse(input logic [7:0] t, input int i);
    @(posedge pclk);
    temps <= ttm_temps_s'(24'(t) << (8 * i));
    mcd   <= 1'b1;
    @(posedge pclk);
    mcd <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask

  // Main sequence
  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rdc(IDX_PIN_CTL, PIN_CTL_RST, "ctl");
    for (int i = 0; i < 3; i++)
      rdc(lim[i], LIMIT_RST, "lim");
    rdc(IDX_RSV_C, RSV_RST, "rsv");
    // Low byte lane not strobed: write must not land
    strb <= 4'he;
    apb(1'b1, IDX_PIN_CTL, 8'h02);
    strb <= 4'hf;
    rdc(IDX_PIN_CTL, PIN_CTL_RST, "no strobe");
    apb(1'b0, 8'h01, 8'h0);
    `CHK("unmapped", 1'b1, er)
    apb(1'b1, IDX_OUT_EN, 8'h07, 2'h1);
    `CHK("misalign", 1'b1, er)
    lock <= 1'b1;
    apb(1'b1, IDX_LIM_R1, 8'h55);
    apb(1'b1, IDX_OUT_EN, 8'h07);
    lock   <= 1'b0;
    clk_en <= 1'b0;
    @(posedge pclk);
    clk_en <= 1'b1;
    rdc(IDX_LIM_R1, LIMIT_RST, "locked lim");
    rdc(IDX_OUT_EN, 8'h0, "locked oen");
    $display("regs done");
    apb(1'b1, IDX_PIN_CTL, 8'h02);
    apb(1'b1, IDX_IRQ_EN, 8'h07);
    // Each zone: equal, once, twice, held, signed release
    for (int i = 0; i < 3; i++)
    begin
      apb(1'b1, lim[i], 8'h20);
      apb(1'b1, IDX_OUT_EN, 8'(1 << i));
      pulse(8'h20, i);
      pulse(8'h20, i);
      rdc(IDX_STATUS, 8'h0, "equal");
      pulse(8'h21, i);
      rdc(IDX_STATUS, 8'h0, "once");
      pulse(8'h21, i);
      `CHK("pin", 1'b0, trip_n)
      `CHK("irq", 1'b1, irq)
      rdc(IDX_IRQ_STS, 8'(1 << i), "irqsts");
      rdc(IDX_STATUS, 8'(1 << i), "set");
      `CHK("irqclr", 1'b0, irq)
      apb(1'b1, IDX_STATUS, 8'h07);
      rdc(IDX_STATUS, 8'(1 << i), "busy");
      pulse(8'h90, i);
      `CHK("pin off", 1'b1, trip_n)
      rdc(IDX_STATUS, 8'(1 << i), "sticky");
      apb(1'b1, IDX_STATUS, 8'(1 << i));
      rdc(IDX_STATUS, 8'h0, "clr");
    end
    // Zone and global gating, then power-good restart
    apb(1'b1, IDX_OUT_EN, 8'h06);
    apb(1'b1, IDX_IRQ_EN, 8'h00);
    pulse(8'h21, 0);
    pulse(8'h21, 0);
    `CHK("zone off", 1'b1, trip_n)
    `CHK("masked", 1'b0, irq)
    apb(1'b1, IDX_PIN_CTL, 8'h00);
    apb(1'b1, IDX_OUT_EN, 8'h01);
    `CHK("ctl off", 1'b1, trip_n)
    apb(1'b1, IDX_PIN_CTL, 8'h02);
    rdc(IDX_STATUS, 8'h01, "ctl on");
    `CHK("ctl pin", 1'b0, trip_n)
    pulse(8'h00, 0);
    restart <= 1'b1;
    @(posedge pclk);
    restart <= 1'b0;
    repeat (3) @(posedge pclk);
    rdc(IDX_STATUS, 8'h0, "pwrgood");
    $display("trip done");
    results();
  end
endmodule
